// ---- dv/sapp_host_model.sv ----
// Purpose: Host controller model driving the converter control lines
// Assumes: Lines change 1 ns after a rising clock edge
// Notes:   Holds each level for at least one full clock
`timescale 1ns/1ps
module sapp_host_model (
    // Clock
    input  wire logic clock,
    // Control lines toward the port
    output logic      select_n,
    output logic      read_convert,
    output logic      byte_sel
);
    initial begin
        select_n     = 1'b1;
        read_convert = 1'b1;
        byte_sel     = 1'b0;
    end

    // One level per clock, so any low pair lasts 40 ns or more
    task automatic drive(input logic s, input logic r, input logic b);
        @(posedge clock);
        #1;
        select_n     = s;
        read_convert = r;
        byte_sel     = b;
    endtask
endmodule

// ---- dv/tb_sar_adc_parallel_port.sv ----
// Purpose: Self-checking bench for the converter host port
// Assumes: Conversion shortened to 4 cycles
// Notes:   Results read as a word, then with the low byte on lines 15..8
`timescale 1ns/1ps
module tb_sar_adc_parallel_port;
    import sapp_pkg::*;
    localparam int CC = 4;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        clock_enable = 1'b1;
    logic        select_n, read_convert, byte_sel;
    logic [15:0] sample_word = 16'h0000;
    logic        busy_n, conv_start;
    logic [15:0] result_out, result_oe;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #20 clock = ~clock;

    sapp_host_model host (.clock(clock), .select_n(select_n),
        .read_convert(read_convert), .byte_sel(byte_sel));
    sapp_port #(.CONV_CYC(CC)) dut (.clock(clock), .reset(reset),
        .clock_enable(clock_enable), .select_n(select_n), .read_convert(read_convert),
        .byte_sel(byte_sel), .sample_word(sample_word), .busy_n(busy_n),
        .result_out(result_out), .result_oe(result_oe), .conv_start(conv_start));

    // ----------------
    // Checks and end
    // ----------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Cut a hung run short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done();
        end
    end

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset();
        repeat (2) @(posedge clock);
        #1;
        reset = 1'b0;
        check({15'h0000, busy_n}, 16'h0001);
        check({15'h0000, conv_start}, 16'h0000);
        check(result_oe, 16'h0000);
        check(result_out, 16'h0000);
        $display("reset test done");
    endtask

    // Enable dropped for 3 clocks right after a start: busy must last 3 clocks longer
    task automatic t_freeze(input logic [15:0] smp);
        int n;
        sample_word = smp;
        host.drive(1'b0, 1'b1, 1'b0);
        host.drive(1'b0, 1'b0, 1'b0);
        @(posedge clock);
        #1;
        clock_enable = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check({15'h0000, busy_n}, 16'h0000);
        check({15'h0000, conv_start}, 16'h0001);
        clock_enable = 1'b1;
        for (n = 1; n < 20 && busy_n === 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        check(16'(n - 1), 16'(CC + 1));
        host.drive(1'b0, 1'b1, 1'b0);
        @(posedge clock);
        #1;
        check(result_out, smp);
        check(result_oe, 16'hFFFF);
        host.drive(1'b1, 1'b1, 1'b0);
        @(posedge clock);
        #1;
        check(result_oe, 16'h0000);
        $display("freeze test done");
    endtask

    task automatic t_conv(input logic [15:0] smp, input bit by_cs);
        int n;
        sample_word = smp;
        if (by_cs) host.drive(1'b1, 1'b0, 1'b0);
        else host.drive(1'b0, 1'b1, 1'b0);
        host.drive(1'b0, 1'b0, 1'b0);
        for (n = 0; n < 5 && busy_n !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        check({15'h0000, busy_n}, 16'h0000);
        check({15'h0000, conv_start}, 16'h0001);
        check(result_oe, 16'h0000);
        // Release, fall again while busy, release: the second fall must die
        for (n = 1; n < 20 && busy_n === 1'b0; n++) begin
            if (n == 2) host.drive(1'b0, 1'b0, 1'b0);
            else host.drive(1'b0, 1'b1, 1'b0);
        end
        check(16'(n - 1), 16'(CC + 1));
        host.drive(1'b0, 1'b1, 1'b0);
        @(posedge clock);
        #1;
        check(result_out, smp);
        check(result_oe, 16'hFFFF);
        host.drive(1'b0, 1'b1, 1'b1);
        @(posedge clock);
        #1;
        check(result_out, {smp[7:0], smp[15:8]});
        check(result_oe, 16'hFFFF);
        host.drive(1'b1, 1'b1, 1'b0);
        @(posedge clock);
        #1;
        check(result_oe, 16'h0000);
        check({15'h0000, busy_n}, 16'h0001);
        $display("conversion test done");
    endtask

    initial begin
        t_reset();
        t_conv(16'h8001, 1'b0);
        t_conv(16'h7FFE, 1'b1);
        t_freeze(16'hA5C3);
        test_done();
    end
endmodule

// ---- hdl/sapp_byte_mux.sv ----
`timescale 1ns/1ps
// Purpose: Word or byte view of the result register
// Assumes: Pure combinational
// Notes:   Select high rotates the lower byte onto the top lanes
module sapp_byte_mux
    import sapp_pkg::*;
#(
    parameter int W = RESULT_W,
    parameter int B = BYTE_W
) (
    sapp_if.mux m
);
    // Select low: whole word, upper byte on the top lanes
    // Select high: lower byte on the top lanes, so a byte-wide host
    // wired to the top lanes reads both halves
    always_comb begin
        m.muxed = m.word;
        if (m.byte_low_sel) begin
            m.muxed = {m.word[B-1:0], m.word[W-1:B]};
        end
    end
endmodule

// ---- hdl/sapp_if.sv ----
`timescale 1ns/1ps
// Purpose: Carries the mux request and its answer inside the port
// Assumes: One clock domain
// Notes:   None
interface sapp_if #(parameter int W = 16, parameter int B = 8);
    logic [W-1:0] word;
    logic         byte_low_sel;
    logic [W-1:0] muxed;
    modport ctrl (output word, output byte_low_sel, input muxed);
    modport mux  (input word, input byte_low_sel, output muxed);
endinterface

// ---- hdl/sapp_pkg.sv ----
// Purpose: Shared constants for the converter parallel port
// Assumes: 25 MHz system clock
// Notes:   Times in ns, counts derived from the clock rate
package sapp_pkg;
    localparam int          CLK_NS          = 40;
    localparam int          RESULT_W        = 16;
    localparam int          BYTE_W          = 8;
    localparam int          CONV_TIME_NS    = 8000;
    localparam int          CONV_CYCLES     = CONV_TIME_NS / CLK_NS;
    localparam int          START_HOLD_NS   = 40;
    localparam int          START_HOLD_CYC  = (START_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [15:0] SAMPLE_RESET    = 16'h0000;

    typedef enum logic [1:0] {
        SAPP_IDLE    = 2'b00,
        SAPP_CONVERT = 2'b01,
        SAPP_UPDATE  = 2'b11
    } sapp_state_t;
endpackage

// ---- hdl/sapp_port.sv ----
`timescale 1ns/1ps
// Purpose: Host port of a 16-bit sampling converter: start, busy, result bus
// Assumes: Host inputs synchronous to clock; sample word supplied by the analog core
// Notes:   Byte select high moves the lower byte onto lines 15..8
module sapp_port
    import sapp_pkg::*;
#(
    parameter int W        = RESULT_W,
    parameter int B        = BYTE_W,
    parameter int CONV_CYC = CONV_CYCLES
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         clock_enable,
    // Host controls
    input  wire logic         select_n,
    input  wire logic         read_convert,
    input  wire logic         byte_sel,
    // Analog core sample, already two's complement
    input  wire logic [W-1:0] sample_word,
    // Host status and result bus
    output logic              busy_n,
    output logic [W-1:0]      result_out,
    output logic [W-1:0]      result_oe,
    output logic              conv_start
);
    // ----------------------------------------
    // Conversion control
    // ----------------------------------------
    sapp_state_t  state;
    sapp_state_t  next_state;
    logic [15:0]  count;
    logic [15:0]  next_count;
    logic [W-1:0] result;
    logic [W-1:0] next_result;
    logic         cmd_prev;
    logic         cmd_now;
    logic         next_busy_n;
    logic         next_start;

    // Combined active-low command: low only when both lines are low
    assign cmd_now = select_n | read_convert;

    always_comb begin
        next_state  = state;
        next_count  = count;
        next_result = result;
        next_busy_n = busy_n;
        next_start  = 1'b0;
        case (state)
            SAPP_IDLE: begin
                // Falling combined command starts; busy already high here
                if (cmd_prev && !cmd_now) begin
                    next_state  = SAPP_CONVERT;
                    next_count  = 16'(CONV_CYC - 1);
                    next_busy_n = 1'b0;
                    next_start  = 1'b1;
                end
            end
            SAPP_CONVERT: begin
                // Commands here are simply not looked at
                if (count == 16'h0000) begin
                    next_state = SAPP_UPDATE;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            SAPP_UPDATE: begin
                // Two's complement passes unchanged, bit 15 is the sign
                next_result = sample_word;
                next_busy_n = 1'b1;
                next_state  = SAPP_IDLE;
            end
            default: begin
                next_state  = SAPP_IDLE;
                next_busy_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state      <= SAPP_IDLE;
            count      <= 16'h0000;
            result     <= RESULT_RESET;
            busy_n     <= 1'b1;
            cmd_prev   <= 1'b1;
            conv_start <= 1'b0;
        end else if (clock_enable) begin
            state      <= next_state;
            count      <= next_count;
            result     <= next_result;
            busy_n     <= next_busy_n;
            cmd_prev   <= cmd_now;
            conv_start <= next_start;
        end
    end

    // ----------------------------------------
    // Result bus
    // ----------------------------------------
    sapp_if #(.W(W), .B(B)) mux_bus ();
    logic [W-1:0] next_out;
    logic [W-1:0] next_oe;

    assign mux_bus.word         = result;
    assign mux_bus.byte_low_sel = byte_sel;

    sapp_byte_mux #(.W(W), .B(B)) u_mux (
        .m (mux_bus.mux)
    );

    // Drive condition, shared by the bus logic and its checks
    function automatic logic bus_enabled(input logic sel_n, input logic rd_cv);
        return !sel_n && rd_cv;
    endfunction

    // Registered output costs one cycle of access time but keeps outputs glitch free
    always_comb begin
        next_out = '0;
        next_oe  = '0;
        // Drive only with select low and read/convert high
        if (bus_enabled(select_n, read_convert)) begin
            next_oe  = '1;
            next_out = mux_bus.muxed;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            result_out <= '0;
            result_oe  <= '0;
        end else if (clock_enable) begin
            result_out <= next_out;
            result_oe  <= next_oe;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_release;
        @(posedge clock) disable iff (reset)
        (clock_enable && (select_n || !read_convert)) |=> (result_oe == '0);
    endproperty
    a_release: assert property (p_release) else $error("bus driven while released");

    property p_drive;
        @(posedge clock) disable iff (reset)
        (clock_enable && bus_enabled(select_n, read_convert) && !byte_sel)
            |=> (result_oe == '1 && result_out == $past(result));
    endproperty
    a_drive: assert property (p_drive) else $error("word view wrong");

    property p_low_byte;
        @(posedge clock) disable iff (reset)
        (clock_enable && bus_enabled(select_n, read_convert) && byte_sel)
            |=> (result_out[W-1:W-B] == $past(result[B-1:0]));
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("lower byte wrong");

    property p_start;
        @(posedge clock) disable iff (reset)
        (clock_enable && busy_n && state == SAPP_IDLE && cmd_prev && !cmd_now)
            |=> (!busy_n && conv_start);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_ignore;
        @(posedge clock) disable iff (reset)
        (clock_enable && !busy_n && state == SAPP_CONVERT && count != 16'h0000)
            |=> (!busy_n && !conv_start);
    endproperty
    a_ignore: assert property (p_ignore) else $error("command during busy");

    property p_busy_rise;
        @(posedge clock) disable iff (reset)
        $rose(busy_n) |-> (result == $past(sample_word));
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose before update");

    property p_no_cmd_no_start;
        @(posedge clock) disable iff (reset)
        (clock_enable && !(cmd_prev && !cmd_now)) |=> !conv_start;
    endproperty
    a_no_cmd_no_start: assert property (p_no_cmd_no_start) else $error("spurious start");

    property p_oe_whole;
        @(posedge clock) disable iff (reset)
        (result_oe == '0) || (result_oe == '1);
    endproperty
    a_oe_whole: assert property (p_oe_whole) else $error("partial enable");

    property p_update;
        @(posedge clock) disable iff (reset)
        (clock_enable && state == SAPP_UPDATE) |=> (busy_n && result == $past(sample_word));
    endproperty
    a_update: assert property (p_update) else $error("result not taken at update");

    property p_busy_hold;
        @(posedge clock) disable iff (reset)
        (clock_enable && state == SAPP_CONVERT) |=> !busy_n;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy released early");

    property p_select_start;
        @(posedge clock) disable iff (reset)
        (clock_enable && state == SAPP_IDLE && cmd_prev && !select_n && !read_convert)
            |=> (!busy_n && conv_start);
    endproperty
    a_select_start: assert property (p_select_start) else $error("select start lost");

    // Frozen enable must leave state, busy, start and the bus outputs as they were
    property p_freeze;
        @(posedge clock) disable iff (reset)
        !clock_enable |=> ($stable(state) && $stable(busy_n) && $stable(result_out)
            && $stable(result_oe) && $stable(conv_start));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
